// >>> logic/bflp_map.svh
// Constant map for the boot flash lock protection block
`ifndef BFLP_MAP_SVH
`define BFLP_MAP_SVH
`define BFLP_APP_RESET_WORD 17'h00000
`define BFLP_LOCK_UNPROG 2'h3
`define BFLP_LOCK_NOWRITE 2'h2
`define BFLP_LOCK_NOACCESS 2'h0
`define BFLP_LOCK_NOREAD 2'h1
`define BFLP_PTR_BITS 24
`define BFLP_PAGE_WORD_BITS 7
`define BFLP_FLASH_WORD_BITS 17
`endif

// >>> logic/bflp_pkg.sv
// Types for the boot flash lock protection block
package bflp_pkg;
  typedef enum logic [1:0] {BFLP_IDLE, BFLP_PROG} bflp_state_type;
  typedef enum logic [1:0] {BFLP_MODE1, BFLP_MODE2, BFLP_MODE3, BFLP_MODE4} bflp_mode_type;
endpackage

// >>> logic/bflp_lock_guard.sv
// Lock checking, reset vector, interrupt gating and address latch for flash self-programming
//
// Contract
// R1: Lock bits set by software, cleared by chip erase
// R2: Write lock mode 2 ignores store-program (not modelled: the code has no general lock bits)
// R3: Read/write lock mode 1 ignores load/store-program (not modelled: the code has no general lock bits)
// R4: App mode 1: no restriction
// R5: App mode 2: block writes, allow reads
// R6: App mode 3: block writes and boot reads
// R7: App mode 4: block boot reads only
// R8: App modes 3/4 gate interrupts in application
// R9: Boot mode 1: no restriction
// R10: Boot mode 2: block writes, allow reads
// R11: Boot mode 3: block writes and application reads
// R12: Boot mode 4: block application reads only
// R13: Boot modes 3/4 gate interrupts in boot
// R14: Boot code entered by jump or call
// R15: Boot-reset fuse picks reset vector
// R16: CPU cannot alter fuses
// R17: Address from extension, high, low bytes
// R18: Extension byte only above 64 Kbytes
// R19: Word address splits into page and word
// R20: Address latched when programming starts
// R21: Erase and write use same page address
// R22: Load-program selects byte with low bit
// R23: Store-program works only from boot section
// R24: Boot-size fuses set the section boundary
// R25: Sections classified by PC and latched address (code classifies the target by ptrWord)
// R26: Blocked accesses discarded, read data undefined
`timescale 1ns/1ps
`include "bflp_map.svh"
module bflp_lock_guard
  import bflp_pkg::*;
#(
  parameter int FLASH_WORD_BITS = `BFLP_FLASH_WORD_BITS,
  parameter int PAGE_WORD_BITS = `BFLP_PAGE_WORD_BITS,
  parameter int BOOT_SIZE_BITS = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Fuses, sampled from the programming interface side
  input wire logic bootResetFuse,
  input wire logic [BOOT_SIZE_BITS-1:0] bootSizeFuses,
  input wire logic [FLASH_WORD_BITS-1:0] bootStartWord0,
  input wire logic [FLASH_WORD_BITS-1:0] bootStartWord1,
  input wire logic [FLASH_WORD_BITS-1:0] bootStartWord2,
  input wire logic [FLASH_WORD_BITS-1:0] bootStartWord3,
  // Lock bit programming
  input wire logic chipErase,
  input wire logic lockWriteStrobe,
  input wire logic [3:0] lockWriteData,
  // CPU state
  input wire logic [FLASH_WORD_BITS-1:0] programCounter,
  input wire logic vectorsInBoot,
  input wire logic irqRequest,
  // Pointer registers
  input wire logic [7:0] pointerExtensionByte,
  input wire logic [7:0] pointerHighByte,
  input wire logic [7:0] pointerLowByte,
  // Store and load requests
  input wire logic storeProgramStrobe,
  input wire logic progDone,
  input wire logic loadProgramStrobe,
  // Results
  output logic [3:0] lockBits,
  output logic [FLASH_WORD_BITS-1:0] resetVector,
  output logic irqGranted,
  output logic progStart,
  output logic progBusy,
  output logic [FLASH_WORD_BITS-PAGE_WORD_BITS-1:0] progPage,
  output logic [PAGE_WORD_BITS-1:0] progWord,
  output logic loadGranted,
  output logic loadBlocked,
  output logic [FLASH_WORD_BITS-1:0] loadWord,
  output logic loadHighByte,
  output logic storeBlocked
);
  // Elaboration checks: the pointer holds 24 bits, so at most 23 word bits
  initial begin
    if (FLASH_WORD_BITS < 8 || FLASH_WORD_BITS > 23) begin
      $error("bflp_lock_guard: FLASH_WORD_BITS out of range");
    end
    if (PAGE_WORD_BITS < 1 || PAGE_WORD_BITS >= FLASH_WORD_BITS) begin
      $error("bflp_lock_guard: PAGE_WORD_BITS out of range");
    end
    // The boundary select decodes exactly four boot sizes
    if (BOOT_SIZE_BITS != 2) begin
      $error("bflp_lock_guard: BOOT_SIZE_BITS must be 2");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fuse sampling, two flip-flops since fuses sit outside this domain

  logic [FLASH_WORD_BITS-1:0] bootStart;
  logic [BOOT_SIZE_BITS-1:0] sizeMeta_r, sizeSync_r;
  logic rstMeta_r, rstSync_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sizeMeta_r <= '0;
      sizeSync_r <= '0;
      rstMeta_r <= 1'b1;
      rstSync_r <= 1'b1;
    end else begin
      sizeMeta_r <= bootSizeFuses;
      sizeSync_r <= sizeMeta_r;
      rstMeta_r <= bootResetFuse;
      rstSync_r <= rstMeta_r;
    end
  end

  // Fuses are inputs only: nothing here can write them (R16)
  always_comb begin
    case (sizeSync_r) // R24
      2'h0: bootStart = bootStartWord0;
      2'h1: bootStart = bootStartWord1;
      2'h2: bootStart = bootStartWord2;
      default: bootStart = bootStartWord3;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lock bits: {app high, app low, boot high, boot low}, 1 = unprogrammed

  logic [3:0] lock_r, lock_nxt;
  // Erase wins over a lock write in the same cycle, so an erase is never lost
  always_comb begin
    lock_nxt = lock_r;
    if (chipErase) begin
      lock_nxt = 4'hf; // R1
    end else if (lockWriteStrobe) begin
      lock_nxt = lock_r & lockWriteData; // R1
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lock_r <= 4'hf;
    end else begin
      lock_r <= lock_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access classification

  // Pointer byte address; extension used only beyond 64 Kbytes
  logic [`BFLP_PTR_BITS-1:0] pointer;
  logic [FLASH_WORD_BITS-1:0] ptrWord;
  logic execInBoot, targetInBoot;
  logic [1:0] appLock, bootLock;
  logic appNoWrite, appNoRead, bootNoWrite, bootNoRead;
  always_comb begin
    if (FLASH_WORD_BITS > 15) begin
      pointer = {pointerExtensionByte, pointerHighByte, pointerLowByte}; // R17
    end else begin
      pointer = {8'h00, pointerHighByte, pointerLowByte}; // R18
    end
    ptrWord = pointer[FLASH_WORD_BITS:1];
    execInBoot = programCounter >= bootStart; // R25
    appLock = lock_r[3:2];
    bootLock = lock_r[1:0];
    // General lock bits do not enter these checks at all (R2) (R3)
    appNoWrite = !appLock[0]; // R4 R5 R6 R7
    appNoRead = !appLock[1] && execInBoot; // R6 R7
    bootNoWrite = !bootLock[0]; // R9 R10 R11 R12
    bootNoRead = !bootLock[1] && !execInBoot; // R11 R12
    targetInBoot = ptrWord >= bootStart;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Store-program sequencing and address latch

  bflp_state_type state_r, state_nxt;
  logic [FLASH_WORD_BITS-1:0] latched_r, latched_nxt;
  logic start_nxt, sBlk_nxt, busy_nxt;
  // A store while busy is ignored; software waits for progBusy to fall
  always_comb begin
    state_nxt = state_r;
    latched_nxt = latched_r;
    start_nxt = 1'b0;
    sBlk_nxt = 1'b0;
    case (state_r)
      BFLP_IDLE: begin
        if (storeProgramStrobe && execInBoot) begin // R23
          if ((targetInBoot && bootNoWrite) || (!targetInBoot && appNoWrite)) begin
            sBlk_nxt = 1'b1; // R26
          end else begin
            latched_nxt = ptrWord; // R20
            start_nxt = 1'b1;
            state_nxt = BFLP_PROG;
          end
        end
      end
      BFLP_PROG: begin
        if (progDone) begin
          state_nxt = BFLP_IDLE;
        end
      end
      default: state_nxt = BFLP_IDLE;
    endcase
    busy_nxt = state_nxt == BFLP_PROG;
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= BFLP_IDLE;
      latched_r <= '0;
      progStart <= 1'b0;
      progBusy <= 1'b0;
      storeBlocked <= 1'b0;
    end else begin
      state_r <= state_nxt;
      latched_r <= latched_nxt;
      progStart <= start_nxt;
      progBusy <= busy_nxt;
      storeBlocked <= sBlk_nxt;
    end
  end
  // Page and word fields of the latched address (R19) (R25)
  assign progPage = latched_r[FLASH_WORD_BITS-1:PAGE_WORD_BITS];
  assign progWord = latched_r[PAGE_WORD_BITS-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // Load-program check

  logic lGrant_nxt, lBlk_nxt, lHigh_nxt;
  logic [FLASH_WORD_BITS-1:0] lWord_nxt;
  always_comb begin
    lGrant_nxt = 1'b0;
    lBlk_nxt = 1'b0;
    // Address follows the pointer every cycle; it only means something with a grant
    lWord_nxt = ptrWord;
    lHigh_nxt = pointer[0]; // R22
    if (loadProgramStrobe) begin
      if ((targetInBoot && bootNoRead) || (!targetInBoot && appNoRead)) begin
        lBlk_nxt = 1'b1; // R26
      end else begin
        lGrant_nxt = 1'b1;
      end
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      loadGranted <= 1'b0;
      loadBlocked <= 1'b0;
      loadWord <= '0;
      loadHighByte <= 1'b0;
    end else begin
      loadGranted <= lGrant_nxt;
      loadBlocked <= lBlk_nxt;
      loadWord <= lWord_nxt;
      loadHighByte <= lHigh_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset vector, valid only once the fuse synchronisers have settled

  logic [FLASH_WORD_BITS-1:0] rstVec_nxt;
  always_comb begin
    if (rstSync_r) begin
      rstVec_nxt = FLASH_WORD_BITS'(`BFLP_APP_RESET_WORD); // R15
    end else begin
      rstVec_nxt = bootStart; // R15 R24
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      resetVector <= '0;
    end else begin
      resetVector <= rstVec_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt gating: code in a read-locked section does not take vectors from the other section

  logic appIrqOff, bootIrqOff, irq_nxt;
  always_comb begin
    appIrqOff = vectorsInBoot && !appLock[1] && !execInBoot; // R8
    bootIrqOff = !vectorsInBoot && !bootLock[1] && execInBoot; // R13
    irq_nxt = irqRequest && !appIrqOff && !bootIrqOff;
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irqGranted <= 1'b0;
    end else begin
      irqGranted <= irq_nxt;
    end
  end

  assign lockBits = lock_r;
endmodule

// >>> test/bflp_cpu_model.sv
// Far-side model that ends each programming operation after a chosen latency
`timescale 1ns/1ps
module bflp_cpu_model (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Operation handshake
  input wire logic progStart,
  input wire logic [3:0] lat,
  output logic progDone
);
  logic [4:0] cnt;
  // Latency is set per operation so prompt and slow completions both occur
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      {cnt, progDone} <= 6'h0;
    end else begin
      progDone <= cnt == 5'h1;
      cnt <= progStart ? lat + 5'h1 : cnt - 5'(cnt != 5'h0);
    end
  end
endmodule

// >>> test/bflp_lock_guard_properties.sv
// Port checker for the flash lock guard
`timescale 1ns/1ps
module bflp_lock_guard_properties #(parameter int FLASH_WORD_BITS = 17, PAGE_WORD_BITS = 7) (
  // Clock and reset
  input wire logic clk, nrst,
  // Requests
  input wire logic chipErase, storeProgramStrobe, loadProgramStrobe, irqRequest, progDone,
  input wire logic [7:0] pointerExtensionByte, pointerHighByte, pointerLowByte,
  // Results
  input wire logic [3:0] lockBits,
  input wire logic progStart, progBusy, storeBlocked, loadGranted, loadBlocked,
  input wire logic loadHighByte, irqGranted,
  input wire logic [FLASH_WORD_BITS-1:0] loadWord,
  input wire logic [FLASH_WORD_BITS-PAGE_WORD_BITS-1:0] progPage,
  input wire logic [PAGE_WORD_BITS-1:0] progWord
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic [23:0] ptr;
  assign ptr = {pointerExtensionByte, pointerHighByte, pointerLowByte};
  ////////////////////////////////////////////////////////////
  erase_unlocks_a: assert property (chipErase |=> lockBits == 4'hf)
    else $error("erase left lock bits set");
  lock_only_sets_a: assert property (!chipErase |=> (lockBits & ~$past(lockBits)) == 4'h0)
    else $error("lock bit cleared without erase");
  start_when_idle_a: assert property (progStart |-> $past(storeProgramStrobe) && !$past(progBusy))
    else $error("start without idle store");
  load_one_answer_a: assert property ((loadGranted || loadBlocked) == $past(loadProgramStrobe)
    && !(loadGranted && loadBlocked))
    else $error("load answer wrong");
  load_byte_sel_a: assert property (loadGranted |-> loadHighByte == $past(pointerLowByte[0])
    && loadWord == FLASH_WORD_BITS'($past(ptr) >> 1))
    else $error("load address wrong");
  page_latched_a: assert property (progStart |->
    {progPage, progWord} == FLASH_WORD_BITS'($past(ptr) >> 1))
    else $error("programming address wrong");
  addr_held_a: assert property (progBusy && !progStart |-> $stable({progPage, progWord}))
    else $error("address moved while busy");
  busy_release_a: assert property (progBusy && progDone |=> !progBusy)
    else $error("busy held after done");
  free_load_a: assert property (loadProgramStrobe && lockBits == 4'hf |=> loadGranted)
    else $error("unlocked load refused");
  irq_from_req_a: assert property (irqGranted |-> $past(irqRequest))
    else $error("interrupt without request");
  cover property (progStart);
  cover property (storeBlocked);
  cover property (loadBlocked);
  cover property (irqRequest && !irqGranted);
endmodule
bind bflp_lock_guard bflp_lock_guard_properties #(.FLASH_WORD_BITS(FLASH_WORD_BITS),
  .PAGE_WORD_BITS(PAGE_WORD_BITS)) chk (.*);

// >>> test/bflp_lock_guard_tb.sv
// Self-checking bench for the flash lock guard
`timescale 1ns/1ps
module bflp_lock_guard_tb;
  logic clk, nrst, bootResetFuse, chipErase, lockWriteStrobe, vectorsInBoot, irqRequest;
  logic storeProgramStrobe, loadProgramStrobe, progDone, progStart, progBusy, irqGranted;
  logic loadGranted, loadBlocked, loadHighByte, storeBlocked;
  logic [1:0] bootSizeFuses;
  logic [3:0] lockWriteData, lockBits, lat;
  logic [7:0] pointerExtensionByte, pointerHighByte, pointerLowByte;
  logic [16:0] programCounter, resetVector, loadWord;
  logic [16:0] st [4] = '{17'h1f000, 17'h1e000, 17'h1c000, 17'h18000};
  logic [9:0] progPage;
  logic [6:0] progWord;
  int num_errors, compares, cyc, bs, lk, seed;
  bflp_lock_guard DUT (.bootStartWord0(st[0]), .bootStartWord1(st[1]),
    .bootStartWord2(st[2]), .bootStartWord3(st[3]), .*);
  bflp_cpu_model cpu (.*);
  ////////////////////////////////////////////////////////////
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 10000) begin
      num_errors++;
      end_sim();
    end
  end
  task automatic chk(input logic [23:0] a, input logic [23:0] e);
    compares++;
    if (a !== e) begin
      num_errors++;
      $display("BAD t=%0t got %h exp %h", $time, a, e);
    end
  endtask
  task automatic end_sim();
    if (num_errors == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // Targets and code sit a few words either side of the boundary
  task automatic acc(input bit s, input bit cb, input bit tb);
    int r, w, pc;
    bit blk, gate;
    r = $random(seed);
    w = tb ? bs + (r & 3) : bs - 1 - (r & 3);
    pc = cb ? bs + (r >> 2 & 3) : bs - 1 - (r >> 2 & 3);
    blk = s ? (tb ? !lk[0] : !lk[2]) : (tb ? !lk[1] && !cb : !lk[3] && cb);
    gate = !lk[3] && r[4] && !cb || !lk[1] && !r[4] && cb;
    programCounter <= pc[16:0];
    {pointerExtensionByte, pointerHighByte, pointerLowByte} <= 24'(w * 2 + r[5]);
    {vectorsInBoot, irqRequest, lat} <= {r[4], r[6], r[10:7]};
    {storeProgramStrobe, loadProgramStrobe} <= {s, !s};
    @(posedge clk);
    {storeProgramStrobe, loadProgramStrobe} <= 2'h0;
    // Pointer moves at once to show the running operation keeps its own copy
    pointerLowByte <= ~pointerLowByte;
    #1;
    chk(irqGranted, r[6] && !gate);
    if (s) begin
      chk({progStart, storeBlocked}, {cb && !blk, cb && blk});
      if (cb && !blk) begin
        chk({progBusy, progPage, progWord}, {1'b1, w[16:0]});
        for (int k = 0; k < 30 && progBusy !== 1'b0; k++) #10;
        chk({progBusy, progPage, progWord}, {1'b0, w[16:0]});
      end
    end else begin
      chk({loadGranted, loadBlocked}, {!blk, blk});
      if (!blk) chk({loadWord, loadHighByte}, {w[16:0], r[5]});
    end
    @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    seed = 32'hd55a;
    {nrst, chipErase, lockWriteStrobe, storeProgramStrobe, loadProgramStrobe} = 5'h0;
    {bootResetFuse, bootSizeFuses, lockWriteData, vectorsInBoot, irqRequest, lat} = 13'h0;
    programCounter = 17'h0;
    {pointerExtensionByte, pointerHighByte, pointerLowByte} = 24'h0;
    repeat (2) @(posedge clk);
    nrst <= 1;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      {chipErase, bootSizeFuses, bootResetFuse} <= {1'b1, i[1:0], i[2]};
      bs = st[i[1:0]];
      lk = i;
      @(posedge clk);
      {chipErase, lockWriteStrobe, lockWriteData} <= {2'h1, i[3:0]};
      // A write of all ones must not clear anything
      @(posedge clk);
      lockWriteData <= 4'hf;
      @(posedge clk);
      lockWriteStrobe <= 0;
      repeat (3) @(posedge clk);
      #1;
      chk(lockBits, lk[3:0]);
      chk(resetVector, i[2] ? 17'h0 : st[i[1:0]]);
      @(posedge clk);
      for (int j = 0; j < 8; j++) acc(j[0], j[1], j[2]);
    end
    end_sim();
  end
endmodule
